// ==== src/rst_if_pkg.sv ====
// Package with the constants and encodings of the processor reset interface.
package rst_if_pkg;
	// =====================================================================
	// Reset type codes, shared by the debug field, watchdog control and history.
	// =====================================================================
	// Two-bit code selecting a reset type.
	typedef logic [1:0] rst_code_t;
	// No reset requested.
	localparam rst_code_t CODE_NONE = 2'h0;
	// Core reset.
	localparam rst_code_t CODE_CORE = 2'h1;
	// Chip reset.
	localparam rst_code_t CODE_CHIP = 2'h2;
	// System or power-on reset.
	localparam rst_code_t CODE_SYS = 2'h3;
	// Value of the most-recent-reset field after the block's own reset.
	localparam rst_code_t MRR_RESET_VAL = 2'h3;
	// =====================================================================
	// Timing.
	// =====================================================================
	// Cycles a request stays up after its reset input is first seen.
	localparam logic [1:0] REQ_HOLD_CYCLES = 2'h2;
	// Least time the partner holds a reset input, in clock cycles.
	localparam int MIN_RESET_CYCLES = 8;
	// Width of the reset input hold counter.
	localparam int HOLD_CNT_W = 4;
	// Count at which a reset input has been held long enough.
	localparam logic [3:0] HOLD_DONE = 4'h8;
endpackage

// ==== src/rst_req_ch.sv ====
// One reset-request channel: raise on a trigger, drop two cycles after the answer.
`timescale 1ns/1ps
module rst_req_ch (
	input wire logic clk,
	input wire logic reset,
	input wire logic raise,
	input wire logic ack_in,
	output logic req
);
	// =====================================================================
	// Request state.
	// =====================================================================
	// Countdown after the acknowledging input was first seen.
	logic [1:0] cnt_r;
	// Set while the countdown is running.
	logic run_r;
	// Request flip-flop.
	logic req_r;

	// The request holds until the countdown expires; a new trigger in the last
	// cycle wins so that no request is lost.
	always_ff @(posedge clk) begin
		if (reset) begin
			req_r <= 1'b0;
			run_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (req_r && ack_in && !run_r) begin
				// Acknowledge seen: start counting the two closing cycles.
				run_r <= 1'b1;
				cnt_r <= rst_if_pkg::REQ_HOLD_CYCLES - 2'h1;
			end else if (run_r && cnt_r != 2'h0) begin
				cnt_r <= cnt_r - 2'h1;
			end else if (run_r) begin
				run_r <= 1'b0;
			end
			if (raise) begin
				req_r <= 1'b1;
			end else if (run_r && cnt_r == 2'h0) begin
				req_r <= 1'b0;
			end
		end
	end

	assign req = req_r;
endmodule

// ==== src/processor_reset_interface.sv ====
// Reset request generation and reset input decoding of the processor block.
`timescale 1ns/1ps
// Function
// - Core request holds until two cycles after input.
// - Chip request holds until two cycles after input.
// - System request holds until two cycles after input.
// - Debug or watchdog code 01 raises core.
// - Debug or watchdog code 10 raises chip.
// - Debug or watchdog code 11 raises system.
// - Core input resets core, caches, controllers.
// - Chip input only records chip type.
// - System input resets only test-access unit.
// - Test reset low resets all logic.
// - History records 01, 10, 11, else keeps.
// - Requests alone never reset anything.
module processor_reset_interface (
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] debug_reset_field,
	input wire logic debug_reset_write,
	input wire logic [1:0] watchdog_reset_control,
	input wire logic watchdog_reset_state,
	input wire logic core_reset_in,
	input wire logic chip_reset_in,
	input wire logic system_reset_in,
	input wire logic test_reset_in_n,
	output logic core_reset_request,
	output logic chip_reset_request,
	output logic system_reset_request,
	output logic core_logic_reset,
	output logic test_unit_reset,
	output logic [1:0] most_recent_reset_field
);
	// =====================================================================
	// Trigger decode.
	// =====================================================================
	// One trigger per reset type, index 0 core, 1 chip, 2 system.
	logic [2:0] raise;
	// Reset inputs gathered by the same index.
	logic [2:0] ack;
	// Requests gathered by the same index.
	logic [2:0] req;
	// Previous watchdog reset-state level, so one time-out raises once.
	logic wd_state_r;

	// Catch the watchdog entering its reset state as an edge.
	always_ff @(posedge clk) begin
		if (reset) begin
			wd_state_r <= 1'b0;
		end else begin
			wd_state_r <= watchdog_reset_state;
		end
	end

	assign ack = {system_reset_in, chip_reset_in, core_reset_in};

	// Each channel compares both sources against its own code.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ch
			// Code served by this channel: its index plus one.
			localparam rst_if_pkg::rst_code_t ch_code = 2'(gi + 1);
			assign raise[gi] = (debug_reset_write && debug_reset_field == ch_code) ||
				(watchdog_reset_state && !wd_state_r &&
				watchdog_reset_control == ch_code);
			rst_req_ch u_ch (
				.clk(clk),
				.reset(reset),
				.raise(raise[gi]),
				.ack_in(ack[gi]),
				.req(req[gi])
			);
		end
	endgenerate

	assign core_reset_request = req[0];
	assign chip_reset_request = req[1];
	assign system_reset_request = req[2];

	// =====================================================================
	// Reset outputs toward the core and the test-access unit.
	// =====================================================================
	// Registered core reset.
	logic core_rst_r;
	// Registered test-access unit reset.
	logic test_rst_r;

	// Only the inputs drive these resets; a request never does. The chip input
	// is deliberately absent here because it resets nothing by itself.
	always_ff @(posedge clk) begin
		if (reset) begin
			core_rst_r <= 1'b1;
			test_rst_r <= 1'b1;
		end else begin
			core_rst_r <= core_reset_in || !test_reset_in_n;
			test_rst_r <= system_reset_in || !test_reset_in_n;
		end
	end

	assign core_logic_reset = core_rst_r;
	assign test_unit_reset = test_rst_r;

	// =====================================================================
	// Most-recent-reset history.
	// =====================================================================
	// History field.
	logic [1:0] mrr_r;
	// Next history value.
	logic [1:0] mrr_nxt;
	// Cycles the core input has been held, saturating.
	logic [3:0] hold_r;

	// Count the hold; a pulse shorter than nine cycles is not taken as a reset,
	// while the partner promises at least eight.
	always_ff @(posedge clk) begin
		if (reset) begin
			hold_r <= 4'h0;
		end else if (!core_reset_in) begin
			hold_r <= 4'h0;
		end else if (hold_r != rst_if_pkg::HOLD_DONE) begin
			hold_r <= hold_r + 4'h1;
		end
	end

	// Decode the combination of inputs into the type code.
	always_comb begin
		mrr_nxt = mrr_r;
		if (!test_reset_in_n) begin
			mrr_nxt = rst_if_pkg::CODE_SYS;
		end else if (core_reset_in && hold_r == rst_if_pkg::HOLD_DONE) begin
			if (system_reset_in) begin
				mrr_nxt = rst_if_pkg::CODE_SYS;
			end else if (chip_reset_in) begin
				mrr_nxt = rst_if_pkg::CODE_CHIP;
			end else begin
				mrr_nxt = rst_if_pkg::CODE_CORE;
			end
		end
	end

	// Register the history.
	always_ff @(posedge clk) begin
		if (reset) begin
			mrr_r <= rst_if_pkg::MRR_RESET_VAL;
		end else begin
			mrr_r <= mrr_nxt;
		end
	end

	assign most_recent_reset_field = mrr_r;

	// =====================================================================
	// Checks.
	// =====================================================================
	a_core_req_raise: assert property (@(posedge clk) disable iff (reset)
		raise[0] |=> core_reset_request)
		else $error("core request not raised");
	a_core_req_drop: assert property (@(posedge clk) disable iff (reset)
		$rose(core_reset_in) && core_reset_request && !raise[0] ##1 !raise[0] ##1 !raise[0]
		|=> !core_reset_request)
		else $error("core request not dropped after two cycles");
	a_chip_req_hold: assert property (@(posedge clk) disable iff (reset)
		$rose(chip_reset_in) && chip_reset_request |=> chip_reset_request)
		else $error("chip request dropped early");
	a_sys_req_drop: assert property (@(posedge clk) disable iff (reset)
		$rose(system_reset_in) && system_reset_request && !raise[2] ##1 !raise[2] ##1 !raise[2]
		|=> !system_reset_request)
		else $error("system request not dropped");
	a_req_no_reset: assert property (@(posedge clk) disable iff (reset)
		core_reset_in == 1'b0 && test_reset_in_n |=> !core_logic_reset)
		else $error("core reset without input");
	a_chip_no_reset: assert property (@(posedge clk) disable iff (reset)
		chip_reset_in && !core_reset_in && test_reset_in_n |=> !core_logic_reset)
		else $error("chip input reset the core");
	a_trst_all: assert property (@(posedge clk) disable iff (reset)
		!test_reset_in_n |=> core_logic_reset && test_unit_reset
		&& most_recent_reset_field == rst_if_pkg::CODE_SYS)
		else $error("test reset did not reset all");
	a_mrr_keep: assert property (@(posedge clk) disable iff (reset)
		!core_reset_in && test_reset_in_n |=> $stable(most_recent_reset_field))
		else $error("history changed without reset");
	a_mrr_core: assert property (@(posedge clk) disable iff (reset)
		core_reset_in && !chip_reset_in && !system_reset_in && test_reset_in_n
		&& hold_r == rst_if_pkg::HOLD_DONE |=> most_recent_reset_field == rst_if_pkg::CODE_CORE)
		else $error("core type not recorded");
	a_sys_test: assert property (@(posedge clk) disable iff (reset)
		system_reset_in |=> test_unit_reset)
		else $error("test unit not reset");
	// A chip trigger must show on its request one edge later.
	a_chip_req_raise: assert property (@(posedge clk) disable iff (reset)
		raise[1] |=> chip_reset_request)
		else $error("chip request not raised");
	// A system trigger must show on its request one edge later.
	a_sys_req_raise: assert property (@(posedge clk) disable iff (reset)
		raise[2] |=> system_reset_request)
		else $error("system request not raised");
	// The chip request closes like the other two, two edges after its input.
	a_chip_req_drop: assert property (@(posedge clk) disable iff (reset)
		$rose(chip_reset_in) && chip_reset_request && !raise[1] ##1 !raise[1] ##1 !raise[1]
		|=> !chip_reset_request)
		else $error("chip request not dropped after two cycles");
	// A low request stays low until a trigger arrives.
	a_core_req_idle: assert property (@(posedge clk) disable iff (reset)
		!core_reset_request && !raise[0] |=> !core_reset_request)
		else $error("core request rose without trigger");
	// Same for the chip channel, which has no fabric reset of its own.
	a_chip_req_idle: assert property (@(posedge clk) disable iff (reset)
		!chip_reset_request && !raise[1] |=> !chip_reset_request)
		else $error("chip request rose without trigger");
	// Same for the system channel.
	a_sys_req_idle: assert property (@(posedge clk) disable iff (reset)
		!system_reset_request && !raise[2] |=> !system_reset_request)
		else $error("system request rose without trigger");
	// A held core and chip pair records the chip type.
	a_mrr_chip: assert property (@(posedge clk) disable iff (reset)
		core_reset_in && chip_reset_in && !system_reset_in && test_reset_in_n
		&& hold_r == rst_if_pkg::HOLD_DONE |=> most_recent_reset_field == rst_if_pkg::CODE_CHIP)
		else $error("chip type not recorded");
	// All three inputs held record the system type.
	a_mrr_sys: assert property (@(posedge clk) disable iff (reset)
		core_reset_in && chip_reset_in && system_reset_in && test_reset_in_n
		&& hold_r == rst_if_pkg::HOLD_DONE |=> most_recent_reset_field == rst_if_pkg::CODE_SYS)
		else $error("system type not recorded");
	// The test-access unit is left alone unless the system or test input asks.
	a_sys_no_test: assert property (@(posedge clk) disable iff (reset)
		!system_reset_in && test_reset_in_n |=> !test_unit_reset)
		else $error("test unit reset without input");
endmodule

// ==== tb/reset_gen_model.sv ====
// Behavioural model of the fabric logic that turns reset requests into reset inputs.
`timescale 1ns/1ps
module reset_gen_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] lat,
	input wire logic core_reset_request,
	input wire logic chip_reset_request,
	input wire logic system_reset_request,
	output logic core_reset_in,
	output logic chip_reset_in,
	output logic system_reset_in
);
	// Cycles the inputs stay up; two spare cycles over the minimum.
	localparam int HOLD = rst_if_pkg::MIN_RESET_CYCLES + 2;
	// Cycle count since the request was taken.
	logic [4:0] cnt_r;
	// Reset type being served, zero when idle.
	logic [1:0] kind_r;
	logic on;
	assign on = (cnt_r >= {1'b0, lat}) && (cnt_r < {1'b0, lat} + HOLD);
	// =====================================================================
	// Request service, all on the processor clock.
	// =====================================================================
	always_ff @(posedge clk) begin
		if (reset) begin
			// Power-on: all inputs asserted together.
			cnt_r <= 5'h0;
			kind_r <= 2'h0;
			{core_reset_in, chip_reset_in, system_reset_in} <= 3'h7;
		end else if (kind_r == 2'h0) begin
			// Highest pending type wins; nothing is driven while idle.
			cnt_r <= 5'h0;
			kind_r <= system_reset_request ? 2'h3 : chip_reset_request ? 2'h2 :
				core_reset_request ? 2'h1 : 2'h0;
			{core_reset_in, chip_reset_in, system_reset_in} <= 3'h0;
		end else begin
			// Legal combinations only, held longer than eight cycles.
			cnt_r <= cnt_r + 5'h1;
			core_reset_in <= on;
			chip_reset_in <= on && (kind_r >= 2'h2);
			system_reset_in <= on && (kind_r == 2'h3);
			if (cnt_r == {1'b0, lat} + HOLD) begin
				kind_r <= 2'h0;
			end
		end
	end
endmodule

// ==== tb/processor_reset_interface_tb_top.sv ====
// Self-checking bench for the processor reset interface.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %0h got %0h", n, e, a); end end
module processor_reset_interface_tb_top;
	// =====================================================================
	// Stimulus and observed signals.
	// =====================================================================
	logic clk = 0, reset = 1, wr = 0, wds = 0, tn = 1;
	logic [1:0] fld = 2'h0, wctl = 2'h0, mrr;
	logic [3:0] lat = 4'h0, reqv;
	logic creq, hreq, sreq, cin, hin, sin, clr, tur;
	int bad_count = 0, total_checks = 0;
	// Requests as a one-hot vector indexed by reset code.
	assign reqv = {sreq, hreq, creq, 1'b0};
	processor_reset_interface dut (.clk(clk), .reset(reset), .debug_reset_field(fld),
		.debug_reset_write(wr), .watchdog_reset_control(wctl), .watchdog_reset_state(wds),
		.core_reset_in(cin), .chip_reset_in(hin), .system_reset_in(sin),
		.test_reset_in_n(tn), .core_reset_request(creq), .chip_reset_request(hreq),
		.system_reset_request(sreq), .core_logic_reset(clr), .test_unit_reset(tur),
		.most_recent_reset_field(mrr));
	reset_gen_model partner (.clk(clk), .reset(reset), .lat(lat), .core_reset_request(creq),
		.chip_reset_request(hreq), .system_reset_request(sreq), .core_reset_in(cin),
		.chip_reset_in(hin), .system_reset_in(sin));
	// Free-running 200 MHz clock.
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One request from debug (src 0) or watchdog (src 1), answered after l cycles.
	task automatic run(input logic [1:0] c, input logic src, input logic [3:0] l);
		int n;
		n = 0;
		@(posedge clk);
		lat <= l;
		if (src) begin
			wctl <= c;
			wds <= 1'b1;
		end else begin
			fld <= c;
			wr <= 1'b1;
		end
		@(posedge clk);
		wr <= 1'b0;
		wds <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		`CHK("request", 4'h1 << c, reqv)
		if (l > 4'h3) begin
			`CHK("early core reset", 1'b0, clr)
		end
		do @(negedge clk); while (cin !== 1'b1 && ++n < 40);
		`CHK("partner answer", 1'b1, cin)
		@(negedge clk);
		`CHK("core reset", 1'b1, clr)
		`CHK("test unit reset", c == 2'h3, tur)
		// The request falls at the second edge after the input is first sampled high.
		@(negedge clk);
		`CHK("request held", 4'h1 << c, reqv)
		@(negedge clk);
		`CHK("request dropped", 4'h0, reqv)
		repeat (12) @(negedge clk);
		`CHK("history", c, mrr)
		`CHK("core reset idle", 1'b0, clr)
		`CHK("test unit idle", 1'b0, tur)
	endtask
	// Code zero from both sources raises nothing.
	task automatic refuse();
		@(posedge clk);
		fld <= 2'h0;
		wctl <= 2'h0;
		wr <= 1'b1;
		wds <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wds <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK("no request", 4'h0, reqv)
	endtask
	// A one-cycle test reset resets everything and records a system type.
	task automatic test_reset();
		@(posedge clk);
		tn <= 1'b0;
		@(posedge clk);
		tn <= 1'b1;
		@(negedge clk);
		`CHK("all reset", 2'h3, {clr, tur})
		repeat (2) @(negedge clk);
		`CHK("history", 2'h3, mrr)
	endtask
	// Main sequence: reset for six cycles, then every code from both sources.
	// The order makes the history change on every run, so a stuck field shows.
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		`CHK("reset outputs", 2'h3, {clr, tur})
		`CHK("reset history", rst_if_pkg::MRR_RESET_VAL, mrr)
		`CHK("reset requests", 4'h0, reqv)
		`CHK("power-on inputs", 3'h7, {cin, hin, sin})
		repeat (4) @(posedge clk);
		refuse();
		for (int i = 1; i < 7; i++) begin
			run(2'((i - 1) % 3 + 1), i > 3, (i > 3) ? 4'h0 : 4'h6);
			if (i == 1) begin
				test_reset();
			end
		end
		conclude();
	end
	// Watchdog: the tests need well under a thousand cycles.
	initial begin
		#10000;
		bad_count++;
		conclude();
	end
endmodule
